//--- verif/aoc_host.sv
// apb host model that programs the configuration registers
`timescale 1ns/1ps
`default_nettype none
module aoc_host (
   input  wire logic        ref_clk,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [31:0] paddr,
   output var  logic [31:0] pwdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
   end
   task xfer(input logic wr, input logic [31:0] a, d, output logic [31:0] rd, output logic er);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d & 32'h7FF;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines stop showing the old request
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule // aoc_host
`default_nettype wire

//--- verif/aoc_regs_props.sv
// assertions for the output configuration register bank
`timescale 1ns/1ps
`default_nettype none
module aoc_regs_props #(
   parameter integer DW = 12
) (
   input wire logic        ref_clk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   input wire logic        sample_vld,
   input wire logic        word_vld,
   input wire logic [2:0]  clk_gain_step,
   input wire logic [2:0]  fine_gain_db,
   input wire logic        two_wire,
   input wire logic        sdr_clk,
   input wire logic        cap_rise,
   input wire logic        bit_split
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   AST_RST_CLEAR: assert property (disable iff (1'b0) !rst_b |=> clk_gain_step == 3'h1
      && !two_wire && !word_vld && fine_gain_db == 3'h0) else $error("reset values wrong");
   AST_WORD_PACE: assert property (sample_vld |=> word_vld) else $error("word missing");
   AST_WORD_IDLE: assert property (!sample_vld |=> !word_vld) else $error("stray word");
   AST_CLKG_RANGE: assert property (clk_gain_step <= 3'h5) else $error("gain step range");
   AST_FGAIN_RANGE: assert property (fine_gain_db <= 3'h6) else $error("fine gain range");
   AST_SDR_TWO: assert property (sdr_clk |-> two_wire) else $error("sdr without two wire");
   AST_EDGE_SDR: assert property (cap_rise |-> sdr_clk) else $error("edge without sdr");
   AST_SPLIT_TWO: assert property (bit_split |-> two_wire) else $error("split in one wire");
   AST_PRIO_WINS: assert property (psel && penable && pwrite && paddr == 32'h34
      && pwdata[10] && pwdata[0] |-> ##2 two_wire) else $error("priority write ignored");
   cover property (sample_vld ##1 word_vld);
   cover property (cap_rise);
   cover property (pslverr);
endmodule // aoc_regs_props
bind aoc_regs aoc_regs_props #(.DW(DW)) aoc_regs_props_i (.ref_clk(ref_clk), .rst_b(rst_b),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pslverr(pslverr), .sample_vld(sample_vld), .word_vld(word_vld),
   .clk_gain_step(clk_gain_step), .fine_gain_db(fine_gain_db), .two_wire(two_wire),
   .sdr_clk(sdr_clk), .cap_rise(cap_rise), .bit_split(bit_split));
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the output configuration register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [6:0]  pins;
   logic [11:0] sample_in, word_out, w1;
   logic        sample_vld, word_vld;
   logic [2:0]  clk_gain_step, fine_gain_db;
   logic        coarse_gain_en, two_wire, sdr_clk, ser_14x, cap_rise, lsb_first, bit_split;
   logic [6:0]  ser;
   int          failures, tests_run;
   assign ser = {two_wire, sdr_clk, ser_14x, cap_rise, coarse_gain_en, lsb_first, bit_split};
   aoc_regs aoc_regs_i (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .pin_two_wire(pins[6]), .pin_sdr_clk(pins[5]), .pin_ser_14x(pins[4]),
      .pin_cap_rise(pins[3]), .pin_coarse_gain(pins[2]), .pin_lsb_first(pins[1]),
      .pin_bit_split(pins[0]), .sample_in(sample_in), .sample_vld(sample_vld),
      .word_out(word_out), .word_vld(word_vld), .clk_gain_step(clk_gain_step),
      .fine_gain_db(fine_gain_db), .coarse_gain_en(coarse_gain_en), .two_wire(two_wire),
      .sdr_clk(sdr_clk), .ser_14x(ser_14x), .cap_rise(cap_rise), .lsb_first(lsb_first),
      .bit_split(bit_split));
   aoc_host aoc_host_i (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task chk(input string n, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask
   // outputs settle one edge after the write commits
   task cfg(input logic [31:0] a, d);
      aoc_host_i.xfer(1'b1, a, d, rd, er);
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task send(input logic [11:0] x);
      @(posedge ref_clk);
      sample_in <= x;
      sample_vld <= 1'b1;
      @(posedge ref_clk);
      sample_vld <= 1'b0;
      @(negedge ref_clk);
      chk("word_vld", word_vld, 1);
   endtask
   task complete_run;
      if (failures == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_reset;
      logic [31:0] a[5] = '{32'h10, 32'h28, 32'h2C, 32'h30, 32'h34};
      foreach (a[i]) begin
         aoc_host_i.xfer(1'b0, a[i], 0, rd, er);
         chk("reset value", rd, 0);
      end
      chk("clk_gain_step", clk_gain_step, 1);
      chk("pready", pready, 1);
   endtask
   task t_clkgain;
      logic [4:0] c[6] = '{5'h18, 5'h00, 5'h0C, 5'h0A, 5'h09, 5'h08};
      foreach (c[i]) begin
         cfg(32'h10, {25'h0, c[i], 2'h0});
         chk("clk_gain_step", clk_gain_step, i);
      end
      // undocumented code falls back to the default step
      cfg(32'h10, 32'h04);
      chk("clk_gain_undoc", clk_gain_step, 1);
   endtask
   task t_fine;
      cfg(32'h30, 32'h600);
      chk("fine_gain_db", fine_gain_db, 6);
      cfg(32'h30, 32'h700);
      chk("fine_gain_db", fine_gain_db, 0);
   endtask
   task t_patterns;
      logic [11:0] e[8] = '{12'h123, 12'h000, 12'hFFF, 12'h0, 12'h123, 12'hD55, 12'hAAA, 12'hFC0};
      cfg(32'h2C, 32'h555);
      cfg(32'h30, 32'h001);
      for (int i = 0; i < 8; i++) begin
         if (i != 3) begin
            cfg(32'h28, i << 5);
            send(12'h123);
            chk("word_out", word_out, e[i]);
         end
      end
      cfg(32'h28, 32'h060);
      send(12'h0);
      w1 = word_out;
      send(12'h0);
      chk("toggle", w1 ^ word_out, 12'hFFF);
      cfg(32'h28, 32'h200);
      send(12'h123);
      chk("format", word_out, 12'h923);
   endtask
   task t_ser;
      @(posedge ref_clk);
      pins <= 7'h7F;
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("pins", ser, 7'h7F);
      cfg(32'h34, 32'h401);
      chk("prio", ser, 7'h40);
      @(posedge ref_clk);
      pins <= 7'h00;
      cfg(32'h34, 32'h4F7);
      chk("all set", ser, 7'h7F);
      cfg(32'h34, 32'h4F6);
      chk("one wire", ser, 7'h16);
      aoc_host_i.xfer(1'b0, 32'h34, 0, rd, er);
      chk("readback", rd, 32'h4F6);
      cfg(32'h34, 32'h0F7);
      chk("prio off", ser, 7'h00);
      aoc_host_i.xfer(1'b0, 32'h3C, 0, rd, er);
      chk("unmapped data", rd, 0);
      chk("unmapped err", er, 1);
   endtask
   // ------------------------------------------------------------
   // clock, watchdog, main sequence
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      complete_run;
   end
   initial begin
      rst_b = 1'b0;
      pins = 7'h00;
      sample_in = 12'h000;
      sample_vld = 1'b0;
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      t_reset;
      t_clkgain;
      t_fine;
      t_patterns;
      t_ser;
      complete_run;
   end
endmodule // testbench
`default_nettype wire

//--- verilog/aoc_defs.vh
// constants for the output configuration register bank
`ifndef AOC_DEFS_VH
`define AOC_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define AOC_IDX_CLK_GAIN     5'h04
`define AOC_IDX_PAT_FMT      5'h0A
`define AOC_IDX_PAT_LOW      5'h0B
`define AOC_IDX_GAIN_TOP     5'h0C
`define AOC_IDX_SER_SETUP    5'h0D

// ----------------------------------------------------------------
// writable bit masks, reset value
// ----------------------------------------------------------------
`define AOC_MASK_CLK_GAIN    11'h07C
`define AOC_MASK_PAT_FMT     11'h2E0
`define AOC_MASK_PAT_LOW     11'h7FF
`define AOC_MASK_GAIN_TOP    11'h701
`define AOC_MASK_SER_SETUP   11'h4F7
`define AOC_REG_RESET        11'h000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define AOC_CLKG_HI          6
`define AOC_CLKG_LO          2
`define AOC_PAT_HI           7
`define AOC_PAT_LO           5
`define AOC_FMT_BIT          9
`define AOC_FGAIN_HI         10
`define AOC_FGAIN_LO         8
`define AOC_PAT_MSB_BIT      0
`define AOC_SER_WIRE2        0
`define AOC_SER_SDR          1
`define AOC_SER_14X          2
`define AOC_SER_RISE         4
`define AOC_SER_CGAIN        5
`define AOC_SER_LSBF         6
`define AOC_SER_BITW         7
`define AOC_SER_PRIO         10

// ----------------------------------------------------------------
// clock gain codes
// ----------------------------------------------------------------
`define AOC_CLKG_MIN         5'h18
`define AOC_CLKG_DEF         5'h00
`define AOC_CLKG_G2          5'h0C
`define AOC_CLKG_G3          5'h0A
`define AOC_CLKG_G4          5'h09
`define AOC_CLKG_MAX         5'h08

// ----------------------------------------------------------------
// pattern selector codes and fixed patterns
// ----------------------------------------------------------------
`define AOC_PAT_NORMAL       3'h0
`define AOC_PAT_ZEROS        3'h1
`define AOC_PAT_ONES         3'h2
`define AOC_PAT_TOGGLE       3'h3
`define AOC_PAT_USER         3'h5
`define AOC_PAT_ALIGN        3'h6
`define AOC_PAT_SYNC         3'h7
`define AOC_WORD_ALIGN       12'hAAA
`define AOC_WORD_TOG_A       12'hAAA
`define AOC_WORD_TOG_B       12'h555
`define AOC_WORD_SYNC        12'hFC0
`define AOC_FGAIN_MAX        3'h6

`endif

//--- verilog/aoc_regs.v
// apb register bank and output word shaping for a quad serial converter
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "aoc_defs.vh"

module aoc_regs #(
   parameter integer DW = 12
) (
   input  wire          ref_clk,
   input  wire          rst_b,
   // apb slave
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [31:0]   paddr,
   input  wire [31:0]   pwdata,
   output wire          pready,
   output wire          pslverr,
   output reg  [31:0]   prdata,
   // parallel configuration pins
   input  wire          pin_two_wire,
   input  wire          pin_sdr_clk,
   input  wire          pin_ser_14x,
   input  wire          pin_cap_rise,
   input  wire          pin_coarse_gain,
   input  wire          pin_lsb_first,
   input  wire          pin_bit_split,
   // conversion samples, twos complement
   input  wire [DW-1:0] sample_in,
   input  wire          sample_vld,
   // shaped output word
   output reg  [DW-1:0] word_out,
   output reg           word_vld,
   // analog and serializer controls
   output reg  [2:0]    clk_gain_step,
   output reg  [2:0]    fine_gain_db,
   output reg           coarse_gain_en,
   output reg           two_wire,
   output reg           sdr_clk,
   output reg           ser_14x,
   output reg           cap_rise,
   output reg           lsb_first,
   output reg           bit_split
);

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   reg  [10:0] clk_gain_q;
   reg  [10:0] pat_fmt_q;
   reg  [10:0] pat_low_q;
   reg  [10:0] gain_top_q;
   reg  [10:0] ser_setup_q;
   reg         tog_q;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire [4:0]  idx;
   wire        aligned;
   wire        in_range;
   wire        hit_clk;
   wire        hit_pat;
   wire        hit_low;
   wire        hit_top;
   wire        hit_ser;
   wire        hit;
   wire        wr_en;
   wire [10:0] wdat;
   reg  [10:0] rd_mux;

   assign idx      = paddr[6:2];
   assign aligned  = (paddr[1:0] == 2'h0);
   assign in_range = (paddr[31:7] == 25'h0000000);
   assign hit_clk  = (idx == `AOC_IDX_CLK_GAIN);
   assign hit_pat  = (idx == `AOC_IDX_PAT_FMT);
   assign hit_low  = (idx == `AOC_IDX_PAT_LOW);
   assign hit_top  = (idx == `AOC_IDX_GAIN_TOP);
   assign hit_ser  = (idx == `AOC_IDX_SER_SETUP);
   assign hit      = aligned & in_range &
                     (hit_clk | hit_pat | hit_low | hit_top | hit_ser);
   assign wr_en    = psel & penable & pwrite & hit;
   assign wdat     = pwdata[10:0];

   // zero wait states; unmapped or misaligned access errors out
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // unused bits are not stored, so they read back zero
   // even if the host ignores the write-zero convention
   always @* begin
      rd_mux = 11'h000;
      if (hit) begin
         if (hit_clk)
            rd_mux = clk_gain_q;
         else if (hit_pat)
            rd_mux = pat_fmt_q;
         else if (hit_low)
            rd_mux = pat_low_q;
         else if (hit_top)
            rd_mux = gain_top_q;
         else
            rd_mux = ser_setup_q;
      end
   end

   // read data captured in the setup phase, stable through access
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         prdata <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= {21'h000000, rd_mux};
      end
   end

   // ----------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         clk_gain_q  <= `AOC_REG_RESET;
         pat_fmt_q   <= `AOC_REG_RESET;
         pat_low_q   <= `AOC_REG_RESET;
         gain_top_q  <= `AOC_REG_RESET;
         ser_setup_q <= `AOC_REG_RESET;
      end else if (wr_en) begin
         if (hit_clk)
            clk_gain_q <= wdat & `AOC_MASK_CLK_GAIN;
         if (hit_pat)
            pat_fmt_q <= wdat & `AOC_MASK_PAT_FMT;
         if (hit_low)
            pat_low_q <= wdat & `AOC_MASK_PAT_LOW;
         if (hit_top)
            gain_top_q <= wdat & `AOC_MASK_GAIN_TOP;
         if (hit_ser)
            ser_setup_q <= wdat & `AOC_MASK_SER_SETUP;
      end
   end

   // ----------------------------------------------------------------
   // field extraction
   // ----------------------------------------------------------------
   wire [4:0]    clkg_code;
   wire [2:0]    pat_sel;
   wire          fmt_bin;
   wire [2:0]    fgain_code;
   wire          prio;
   wire [DW-1:0] user_word;

   assign clkg_code  = clk_gain_q[`AOC_CLKG_HI:`AOC_CLKG_LO];
   assign pat_sel    = pat_fmt_q[`AOC_PAT_HI:`AOC_PAT_LO];
   assign fmt_bin    = pat_fmt_q[`AOC_FMT_BIT];
   assign fgain_code = gain_top_q[`AOC_FGAIN_HI:`AOC_FGAIN_LO];
   assign prio       = ser_setup_q[`AOC_SER_PRIO];
   // user pattern: bit 11 from the top register, rest in place
   assign user_word  = {gain_top_q[`AOC_PAT_MSB_BIT],
                        pat_low_q[10:0]};

   // ----------------------------------------------------------------
   // serializer source: pins unless the priority bit is set
   // ----------------------------------------------------------------
   wire src_two;
   wire src_sdr;
   wire src_14x;
   wire src_rise;
   wire src_cg;
   wire src_lsbf;
   wire src_bitw;

   assign src_two  = prio ? ser_setup_q[`AOC_SER_WIRE2] : pin_two_wire;
   assign src_sdr  = prio ? ser_setup_q[`AOC_SER_SDR]   : pin_sdr_clk;
   assign src_14x  = prio ? ser_setup_q[`AOC_SER_14X]   : pin_ser_14x;
   assign src_rise = prio ? ser_setup_q[`AOC_SER_RISE]  : pin_cap_rise;
   assign src_cg   = prio ? ser_setup_q[`AOC_SER_CGAIN] : pin_coarse_gain;
   assign src_lsbf = prio ? ser_setup_q[`AOC_SER_LSBF]  : pin_lsb_first;
   assign src_bitw = prio ? ser_setup_q[`AOC_SER_BITW]  : pin_bit_split;

   // ----------------------------------------------------------------
   // control outputs, registered
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         clk_gain_step  <= 3'h1;
         fine_gain_db   <= 3'h0;
         coarse_gain_en <= 1'b0;
         two_wire       <= 1'b0;
         sdr_clk        <= 1'b0;
         ser_14x        <= 1'b0;
         cap_rise       <= 1'b0;
         lsb_first      <= 1'b0;
         bit_split      <= 1'b0;
      end else begin
         // undocumented codes fall back to the reset step
         case (clkg_code)
            `AOC_CLKG_MIN: clk_gain_step <= 3'h0;
            `AOC_CLKG_DEF: clk_gain_step <= 3'h1;
            `AOC_CLKG_G2:  clk_gain_step <= 3'h2;
            `AOC_CLKG_G3:  clk_gain_step <= 3'h3;
            `AOC_CLKG_G4:  clk_gain_step <= 3'h4;
            `AOC_CLKG_MAX: clk_gain_step <= 3'h5;
            default:       clk_gain_step <= 3'h1;
         endcase
         // code 111 undefined; held at 0 dB rather than guessed
         if (fgain_code > `AOC_FGAIN_MAX)
            fine_gain_db <= 3'h0;
         else
            fine_gain_db <= fgain_code;
         coarse_gain_en <= src_cg;
         two_wire       <= src_two;
         ser_14x        <= src_14x;
         // rate choice only exists with two lanes
         sdr_clk        <= src_two & src_sdr;
         // edge choice only meaningful at single rate
         cap_rise       <= src_two & src_sdr & src_rise;
         lsb_first      <= src_lsbf;
         bit_split      <= src_two & src_bitw;
      end
   end

   // ----------------------------------------------------------------
   // output word shaping
   // ----------------------------------------------------------------
   reg [DW-1:0] conv_word;
   reg [DW-1:0] next_word;

   always @* begin
      conv_word = sample_in;
      // offset binary is twos complement with the sign flipped
      if (fmt_bin)
         conv_word[DW-1] = ~sample_in[DW-1];
   end

   always @* begin
      next_word = conv_word;
      case (pat_sel)
         `AOC_PAT_NORMAL: next_word = conv_word;
         `AOC_PAT_ZEROS:  next_word = {DW{1'b0}};
         `AOC_PAT_ONES:   next_word = {DW{1'b1}};
         `AOC_PAT_TOGGLE: next_word = tog_q ? `AOC_WORD_TOG_B
                                            : `AOC_WORD_TOG_A;
         `AOC_PAT_USER:   next_word = user_word;
         `AOC_PAT_ALIGN:  next_word = `AOC_WORD_ALIGN;
         `AOC_PAT_SYNC:   next_word = `AOC_WORD_SYNC;
         // unused code: pass conversion data, safest for a receiver
         default:         next_word = conv_word;
      endcase
   end

   always @(posedge ref_clk) begin
      if (!rst_b) begin
         word_out <= {DW{1'b0}};
         word_vld <= 1'b0;
         tog_q    <= 1'b0;
      end else begin
         word_vld <= sample_vld;
         if (sample_vld) begin
            word_out <= next_word;
            // toggle phase advances per sample, in any mode
            tog_q    <= ~tog_q;
         end
      end
   end

endmodule // aoc_regs

`default_nettype wire
